/* File: rvie_defs.svh */
// offsets, field positions, reset values and masks for the reset/irq-enable block
`ifndef RVIE_DEFS_SVH
`define RVIE_DEFS_SVH
`define RVIE_ADDR_W 4
`define RVIE_OFF_ENABLE 4'h0
`define RVIE_OFF_PC 4'h1
`define RVIE_OFF_PENDING 4'h2
`define RVIE_OFF_EXT_SEL 4'h3
`define RVIE_ENABLE_RESET 16'h0000
`define RVIE_ENABLE_MASK 16'hFEDF
`define RVIE_RESET_ADDR 24'h000000
`define RVIE_PC_STEP 24'h000002
`define RVIE_BIT_SER2_TX 15
`define RVIE_BIT_SER2_RX 14
`define RVIE_BIT_EXT2 13
`define RVIE_BIT_TMR5 12
`define RVIE_BIT_TMR4 11
`define RVIE_BIT_CMP4 10
`define RVIE_BIT_CMP3 9
`define RVIE_BIT_CAP8 7
`define RVIE_BIT_CAP7 6
`define RVIE_BIT_EXT1 4
`define RVIE_BIT_CHG 3
`define RVIE_BIT_CMPR 2
`define RVIE_BIT_I2CM 1
`define RVIE_BIT_I2CS 0
`define RVIE_SEL_W 4
`define RVIE_SEL_NONE 4'h0
`endif

/* File: rvie_pkg.sv */
// types for the reset/irq-enable block
package rvie_pkg;
    typedef enum logic [0:0] {
        RVIE_HELD = 1'b0,
        RVIE_FETCH = 1'b1
    } rvie_phase_t;

    typedef struct packed {
        rvie_phase_t phase;
        logic [15:0] enable;
        logic [23:0] program_counter;
        logic [3:0] ext1_sel;
        logic [3:0] ext2_sel;
        logic [15:0] rdata;
        logic fetch_req;
    } rvie_state_t;
endpackage : rvie_pkg

/* File: rvie_reset_irq_enable.sv */
// reset entry and interrupt enable bank one
// Overview of operation
// - Reset is handled outside the interrupt path: no vector fetch, priority or exception work happens on reset.
// - Reset returns all registers to reset value, clearing every implemented enable bit.
// - Reset forces the program counter to zero and fetch starts at address 000000h on release.
// - Bits 15..9 enable serial2 tx, serial2 rx, ext irq two, timer five, timer four, compare 4, compare 3; bit 8 unused.
// - An enabled external irq is sourced only from the remappable pin selected for it, never by the enable alone.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "rvie_defs.svh"
module rvie_reset_irq_enable
    import rvie_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [`RVIE_ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic [15:0] i_irq_req,
    input wire logic [14:0] i_remappable_input_pin,
    input wire logic i_fetch_ack,
    output logic [15:0] o_irq_gated,
    output logic o_irq_any,
    output logic [23:0] o_program_counter,
    output logic o_fetch_req
);
    rvie_state_t cur;
    rvie_state_t next_cur;
    logic [15:0] req_src;
    logic ext1_pin;
    logic ext2_pin;
    logic [14:0] ext1_hit;
    logic [14:0] ext2_hit;
    logic sel_enable;
    logic sel_pc;
    logic sel_pending;
    logic sel_ext_sel;
    logic [15:0] enable_view;
    logic [15:0] write_value;
    logic [15:0] read_value;

    // named views of the enable bank
    logic serial2_transmit_irq_enable;
    logic serial2_receive_irq_enable;
    logic external_irq_two_enable;
    logic timer_five_irq_enable;
    logic timer_four_irq_enable;
    logic compare_ch4_irq_enable;
    logic compare_ch3_irq_enable;
    logic capture_ch8_irq_enable;
    logic capture_ch7_irq_enable;
    logic external_irq_one_enable;
    logic change_notify_irq_enable;
    logic comparator_irq_enable;
    logic i2c_one_master_irq_enable;
    logic i2c_one_slave_irq_enable;

    // named request lines as they reach the gate
    logic serial2_transmit_req;
    logic serial2_receive_req;
    logic external_two_req;
    logic timer_five_req;
    logic timer_four_req;
    logic compare_ch4_req;
    logic compare_ch3_req;
    logic capture_ch8_req;
    logic capture_ch7_req;
    logic external_one_req;
    logic change_notify_req;
    logic comparator_req;
    logic i2c_one_master_req;
    logic i2c_one_slave_req;

    // named gated lines toward the core
    logic serial2_transmit_gated;
    logic serial2_receive_gated;
    logic external_two_gated;
    logic timer_five_gated;
    logic timer_four_gated;
    logic compare_ch4_gated;
    logic compare_ch3_gated;
    logic capture_ch8_gated;
    logic capture_ch7_gated;
    logic external_one_gated;
    logic change_notify_gated;
    logic comparator_gated;
    logic i2c_one_master_gated;
    logic i2c_one_slave_gated;

    // selector 0 means unassigned; 1..15 pick pin index sel-1
    genvar p;
    generate
        for (p = 0; p < 15; p++) begin : g_pin_route
            assign ext1_hit[p] = (cur.ext1_sel == 4'(p + 1)) & i_remappable_input_pin[p];
            assign ext2_hit[p] = (cur.ext2_sel == 4'(p + 1)) & i_remappable_input_pin[p];
        end
    endgenerate
    // an unassigned selector matches no pin, so the source stays low
    assign ext1_pin = |ext1_hit;
    assign ext2_pin = |ext2_hit;

    // register index decode shared by the write and read paths
    always_comb begin
        sel_enable = 1'b0;
        sel_pc = 1'b0;
        sel_pending = 1'b0;
        sel_ext_sel = 1'b0;
        if (i_addr == `RVIE_OFF_ENABLE) begin
            sel_enable = 1'b1;
        end else if (i_addr == `RVIE_OFF_PC) begin
            sel_pc = 1'b1;
        end else if (i_addr == `RVIE_OFF_PENDING) begin
            sel_pending = 1'b1;
        end else if (i_addr == `RVIE_OFF_EXT_SEL) begin
            sel_ext_sel = 1'b1;
        end
    end

    // external sources come only from the pin route, never from i_irq_req
    assign serial2_transmit_req = i_irq_req[`RVIE_BIT_SER2_TX];
    assign serial2_receive_req = i_irq_req[`RVIE_BIT_SER2_RX];
    assign external_two_req = ext2_pin;
    assign timer_five_req = i_irq_req[`RVIE_BIT_TMR5];
    assign timer_four_req = i_irq_req[`RVIE_BIT_TMR4];
    assign compare_ch4_req = i_irq_req[`RVIE_BIT_CMP4];
    assign compare_ch3_req = i_irq_req[`RVIE_BIT_CMP3];
    assign capture_ch8_req = i_irq_req[`RVIE_BIT_CAP8];
    assign capture_ch7_req = i_irq_req[`RVIE_BIT_CAP7];
    assign external_one_req = ext1_pin;
    assign change_notify_req = i_irq_req[`RVIE_BIT_CHG];
    assign comparator_req = i_irq_req[`RVIE_BIT_CMPR];
    assign i2c_one_master_req = i_irq_req[`RVIE_BIT_I2CM];
    assign i2c_one_slave_req = i_irq_req[`RVIE_BIT_I2CS];

    // unimplemented positions 8 and 5 stay low in every assembled word
    always_comb begin
        req_src = 16'h0000;
        req_src[`RVIE_BIT_SER2_TX] = serial2_transmit_req;
        req_src[`RVIE_BIT_SER2_RX] = serial2_receive_req;
        req_src[`RVIE_BIT_EXT2] = external_two_req;
        req_src[`RVIE_BIT_TMR5] = timer_five_req;
        req_src[`RVIE_BIT_TMR4] = timer_four_req;
        req_src[`RVIE_BIT_CMP4] = compare_ch4_req;
        req_src[`RVIE_BIT_CMP3] = compare_ch3_req;
        req_src[`RVIE_BIT_CAP8] = capture_ch8_req;
        req_src[`RVIE_BIT_CAP7] = capture_ch7_req;
        req_src[`RVIE_BIT_EXT1] = external_one_req;
        req_src[`RVIE_BIT_CHG] = change_notify_req;
        req_src[`RVIE_BIT_CMPR] = comparator_req;
        req_src[`RVIE_BIT_I2CM] = i2c_one_master_req;
        req_src[`RVIE_BIT_I2CS] = i2c_one_slave_req;
    end

    assign serial2_transmit_irq_enable = cur.enable[`RVIE_BIT_SER2_TX];
    assign serial2_receive_irq_enable = cur.enable[`RVIE_BIT_SER2_RX];
    assign external_irq_two_enable = cur.enable[`RVIE_BIT_EXT2];
    assign timer_five_irq_enable = cur.enable[`RVIE_BIT_TMR5];
    assign timer_four_irq_enable = cur.enable[`RVIE_BIT_TMR4];
    assign compare_ch4_irq_enable = cur.enable[`RVIE_BIT_CMP4];
    assign compare_ch3_irq_enable = cur.enable[`RVIE_BIT_CMP3];
    assign capture_ch8_irq_enable = cur.enable[`RVIE_BIT_CAP8];
    assign capture_ch7_irq_enable = cur.enable[`RVIE_BIT_CAP7];
    assign external_irq_one_enable = cur.enable[`RVIE_BIT_EXT1];
    assign change_notify_irq_enable = cur.enable[`RVIE_BIT_CHG];
    assign comparator_irq_enable = cur.enable[`RVIE_BIT_CMPR];
    assign i2c_one_master_irq_enable = cur.enable[`RVIE_BIT_I2CM];
    assign i2c_one_slave_irq_enable = cur.enable[`RVIE_BIT_I2CS];

    always_comb begin
        enable_view = 16'h0000;
        enable_view[`RVIE_BIT_SER2_TX] = serial2_transmit_irq_enable;
        enable_view[`RVIE_BIT_SER2_RX] = serial2_receive_irq_enable;
        enable_view[`RVIE_BIT_EXT2] = external_irq_two_enable;
        enable_view[`RVIE_BIT_TMR5] = timer_five_irq_enable;
        enable_view[`RVIE_BIT_TMR4] = timer_four_irq_enable;
        enable_view[`RVIE_BIT_CMP4] = compare_ch4_irq_enable;
        enable_view[`RVIE_BIT_CMP3] = compare_ch3_irq_enable;
        enable_view[`RVIE_BIT_CAP8] = capture_ch8_irq_enable;
        enable_view[`RVIE_BIT_CAP7] = capture_ch7_irq_enable;
        enable_view[`RVIE_BIT_EXT1] = external_irq_one_enable;
        enable_view[`RVIE_BIT_CHG] = change_notify_irq_enable;
        enable_view[`RVIE_BIT_CMPR] = comparator_irq_enable;
        enable_view[`RVIE_BIT_I2CM] = i2c_one_master_irq_enable;
        enable_view[`RVIE_BIT_I2CS] = i2c_one_slave_irq_enable;
    end

    // only implemented bits are taken from a write
    always_comb begin
        write_value = 16'h0000;
        write_value[`RVIE_BIT_SER2_TX] = i_wdata[`RVIE_BIT_SER2_TX];
        write_value[`RVIE_BIT_SER2_RX] = i_wdata[`RVIE_BIT_SER2_RX];
        write_value[`RVIE_BIT_EXT2] = i_wdata[`RVIE_BIT_EXT2];
        write_value[`RVIE_BIT_TMR5] = i_wdata[`RVIE_BIT_TMR5];
        write_value[`RVIE_BIT_TMR4] = i_wdata[`RVIE_BIT_TMR4];
        write_value[`RVIE_BIT_CMP4] = i_wdata[`RVIE_BIT_CMP4];
        write_value[`RVIE_BIT_CMP3] = i_wdata[`RVIE_BIT_CMP3];
        write_value[`RVIE_BIT_CAP8] = i_wdata[`RVIE_BIT_CAP8];
        write_value[`RVIE_BIT_CAP7] = i_wdata[`RVIE_BIT_CAP7];
        write_value[`RVIE_BIT_EXT1] = i_wdata[`RVIE_BIT_EXT1];
        write_value[`RVIE_BIT_CHG] = i_wdata[`RVIE_BIT_CHG];
        write_value[`RVIE_BIT_CMPR] = i_wdata[`RVIE_BIT_CMPR];
        write_value[`RVIE_BIT_I2CM] = i_wdata[`RVIE_BIT_I2CM];
        write_value[`RVIE_BIT_I2CS] = i_wdata[`RVIE_BIT_I2CS];
    end

    // unmapped indices read as zero
    always_comb begin
        read_value = 16'h0000;
        if (sel_enable) begin
            read_value = enable_view;
        end else if (sel_pc) begin
            read_value = cur.program_counter[15:0];
        end else if (sel_pending) begin
            read_value = o_irq_gated;
        end else if (sel_ext_sel) begin
            read_value = {8'h00, cur.ext2_sel, cur.ext1_sel};
        end
    end

    assign serial2_transmit_gated = o_irq_gated[`RVIE_BIT_SER2_TX];
    assign serial2_receive_gated = o_irq_gated[`RVIE_BIT_SER2_RX];
    assign external_two_gated = o_irq_gated[`RVIE_BIT_EXT2];
    assign timer_five_gated = o_irq_gated[`RVIE_BIT_TMR5];
    assign timer_four_gated = o_irq_gated[`RVIE_BIT_TMR4];
    assign compare_ch4_gated = o_irq_gated[`RVIE_BIT_CMP4];
    assign compare_ch3_gated = o_irq_gated[`RVIE_BIT_CMP3];
    assign capture_ch8_gated = o_irq_gated[`RVIE_BIT_CAP8];
    assign capture_ch7_gated = o_irq_gated[`RVIE_BIT_CAP7];
    assign external_one_gated = o_irq_gated[`RVIE_BIT_EXT1];
    assign change_notify_gated = o_irq_gated[`RVIE_BIT_CHG];
    assign comparator_gated = o_irq_gated[`RVIE_BIT_CMPR];
    assign i2c_one_master_gated = o_irq_gated[`RVIE_BIT_I2CM];
    assign i2c_one_slave_gated = o_irq_gated[`RVIE_BIT_I2CS];

    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_gate
            assign o_irq_gated[g] = req_src[g] & cur.enable[g];
        end
    endgenerate

    // the request output only summarises; reset forces it low only by clearing the enables
    assign o_irq_any = serial2_transmit_gated
        | serial2_receive_gated
        | external_two_gated
        | timer_five_gated
        | timer_four_gated
        | compare_ch4_gated
        | compare_ch3_gated
        | capture_ch8_gated
        | capture_ch7_gated
        | external_one_gated
        | change_notify_gated
        | comparator_gated
        | i2c_one_master_gated
        | i2c_one_slave_gated;
    assign o_rdata = cur.rdata;
    assign o_program_counter = cur.program_counter;
    assign o_fetch_req = cur.fetch_req;

    always_comb begin
        next_cur = cur;
        // unimplemented bits 8 and 5 are masked so they always read zero
        if (i_wr && sel_enable) begin
            next_cur.enable = write_value;
        end
        if (i_wr && sel_ext_sel) begin
            next_cur.ext1_sel = i_wdata[3:0];
            next_cur.ext2_sel = i_wdata[7:4];
        end
        // read data stand for one cycle only
        next_cur.rdata = 16'h0000;
        if (i_rd) begin
            next_cur.rdata = read_value;
        end
        // first edge after release: issue fetch at the reset address
        case (cur.phase)
            RVIE_HELD: begin
                next_cur.phase = RVIE_FETCH;
                next_cur.fetch_req = 1'b1;
            end
            RVIE_FETCH: begin
                next_cur.fetch_req = 1'b1;
                if (i_fetch_ack) begin
                    next_cur.program_counter = cur.program_counter + `RVIE_PC_STEP;
                end
            end
            default: begin
                next_cur.phase = RVIE_HELD;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cur.phase <= RVIE_HELD;
            cur.enable <= `RVIE_ENABLE_RESET;
            cur.program_counter <= `RVIE_RESET_ADDR;
            cur.ext1_sel <= `RVIE_SEL_NONE;
            cur.ext2_sel <= `RVIE_SEL_NONE;
            cur.rdata <= 16'h0000;
            cur.fetch_req <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end
endmodule : rvie_reset_irq_enable

/* File: rvie_core_model.sv */
// core stand-in that accepts fetches while told to run
`timescale 1ns/1ps
module rvie_core_model (
    input wire logic i_run,
    input wire logic i_fetch_req,
    output logic o_fetch_ack
);
    assign o_fetch_ack = i_run & i_fetch_req;
endmodule : rvie_core_model

/* File: rvie_reset_irq_enable_properties.sv */
// port checks for the reset/irq-enable block
`timescale 1ns/1ps
module rvie_reset_irq_enable_properties (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_rd,
    input wire logic [15:0] i_irq_req,
    input wire logic i_fetch_ack,
    input wire logic [15:0] o_rdata,
    input wire logic [15:0] o_irq_gated,
    input wire logic o_irq_any,
    input wire logic [23:0] o_program_counter,
    input wire logic o_fetch_req
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // must hold while reset is asserted, so not disabled by it
    chk_reset_quiet: assert property (disable iff (1'b0) !i_rst_b |-> !o_fetch_req && o_irq_gated == 16'h0)
        else $error("active in reset");
    chk_unused_bits: assert property ((o_irq_gated & 16'h0120) == 16'h0) else $error("unused bit");
    chk_gate_cause: assert property ((o_irq_gated & ~i_irq_req & 16'hDFEF) == 16'h0) else $error("no request");
    chk_any_or: assert property (o_irq_any == (o_irq_gated != 16'h0)) else $error("summary wrong");
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0) else $error("stray read data");
    chk_fetch_start: assert property ($rose(o_fetch_req) |-> o_program_counter == 24'h0) else $error("start");
    chk_pc_step: assert property (o_fetch_req && i_fetch_ack |=> o_program_counter == $past(o_program_counter) + 24'h2)
        else $error("pc step");
    chk_pc_hold: assert property (o_fetch_req && !i_fetch_ack |=> $stable(o_program_counter)) else $error("pc moved");
endmodule : rvie_reset_irq_enable_properties
bind rvie_reset_irq_enable rvie_reset_irq_enable_properties i_rvie_reset_irq_enable_properties (.*);

/* File: test_reset_vector_and_irq_enable1.sv */
// testbench for the reset/irq-enable block
`timescale 1ns/1ps
`include "rvie_defs.svh"
module test_reset_vector_and_irq_enable1;
    logic clk = 0, rst_b = 1, wr = 0, rd = 0, run = 0, ack, any, freq;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0, req = 16'h0, rdata, gated;
    logic [14:0] pins = 15'h0;
    logic [23:0] pc;
    int num_errors = 0, comparisons = 0;
    rvie_reset_irq_enable i_rvie_reset_irq_enable (.i_core_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_irq_req(req), .i_remappable_input_pin(pins), .i_fetch_ack(ack),
        .o_irq_gated(gated), .o_irq_any(any), .o_program_counter(pc), .o_fetch_req(freq));
    rvie_core_model i_rvie_core_model (.i_run(run), .i_fetch_req(freq), .o_fetch_ack(ack));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [31:0] v, input logic [31:0] e);
        comparisons++;
        if (v !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, v, e);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_chk
    task automatic t_mask;
        wr_reg(`RVIE_OFF_ENABLE, 16'hFFFF);
        rd_chk(`RVIE_OFF_ENABLE, 16'hFEDF);
        @(posedge clk);
        req <= 16'hFFFF;
        // unassigned selectors: external bits must stay dark
        #1 chk(gated, 16'hDECF);
        wr_reg(`RVIE_OFF_EXT_SEL, 16'h0021);
        pins <= 15'h0003;
        #1 chk(gated, 16'hFEDF);
        chk(any, 1'b1);
        rd_chk(`RVIE_OFF_PENDING, 16'hFEDF);
        rd_chk(`RVIE_OFF_EXT_SEL, 16'h0021);
        wr_reg(`RVIE_OFF_PC, 16'hFFFF);
        rd_chk(`RVIE_OFF_PC, 16'h0000);
        rd_chk(4'h7, 16'h0000);
        wr_reg(`RVIE_OFF_ENABLE, 16'h0000);
        #1 chk(gated, 16'h0000);
        chk(any, 1'b0);
    endtask : t_mask
    task automatic t_rereset;
        wr_reg(`RVIE_OFF_ENABLE, 16'hFFFF);
        rst_b <= 1'b0;
        #1 chk({freq, gated}, 17'h0);
        chk(any, 1'b0);
        @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 chk({freq, pc}, 25'h1000000);
        rd_chk(`RVIE_OFF_ENABLE, 16'h0000);
    endtask : t_rereset
    task automatic print_verdict;
        if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 chk({freq, pc}, 25'h1000000);
        rd_chk(`RVIE_OFF_ENABLE, 16'h0000);
        t_mask();
        @(posedge clk);
        run <= 1'b1;
        repeat (3) @(posedge clk);
        run <= 1'b0;
        #1 chk(pc, 24'h000006);
        rd_chk(`RVIE_OFF_PC, 16'h0006);
        t_rereset();
        print_verdict();
    end
    initial begin
        #20000;
        num_errors++;
        print_verdict();
    end
endmodule : test_reset_vector_and_irq_enable1
